// ==== dv/tb_top.sv ====
// self-checking bench for the synchronous slave transmitter
// assumes: pull-up on the data pin, outside master model drives the link clock
`timescale 1ns/1ps
module tb_top;
    logic                        clk;
    logic                        rst;
    logic [ustx_pkg::ADDR_W-1:0] addr;
    logic [7:0]                  wdata;
    logic                        wr;
    logic                        rd;
    logic                        sleep;
    logic                        ck;
    logic                        dt;
    logic [7:0]                  rdata;
    logic                        dt_out;
    logic                        dt_oe;
    logic                        irq;
    logic                        wake;
    logic                        vec;
    logic [31:0]                 seed;
    logic [7:0]                  rv;
    logic [8:0]                  got;
    logic [7:0]                  d1;
    logic [7:0]                  d2;
    logic                        nine;
    logic                        b9;
    int                          bad_count;
    int                          check_count;
    // configurations that must keep the port off
    localparam logic [7:0] OFF_CFG [6] = '{8'h50, 8'h53, 8'h55, 8'h59, 8'h41, 8'h11};

    // clock and pin level with pull-up
    initial clk = 1'b0;
    always #5 clk = ~clk;
    assign dt = dt_oe ? dt_out : 1'b1;

    ustx_top dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_SLEEP(sleep), .I_CK(ck), .I_DT(dt), .O_DT(dt_out),
        .O_DT_OE(dt_oe), .O_IRQ(irq), .O_WAKE(wake), .O_VECTOR(vec));
    ustx_master mst (.i_dt(dt), .o_ck(ck));

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // comparison of any result
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] seen);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // register port cycles
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(nm, {1'b0, e & m}, {1'b0, rdata & m});
    endtask

    // xorshift source and expected frame contents
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic rnd;
        seed = xs(seed);
        rv   = seed[7:0];
    endtask
    function automatic logic [8:0] exp_word(input logic [7:0] d, input logic n9, input logic x);
        return n9 ? {x, d} : {1'b0, d};
    endfunction

    // clock one character out and compare it
    task automatic send(input logic n9, input logic [7:0] d, input logic x, input string nm);
        repeat (4) @(posedge clk);
        mst.frame(n9 ? 9 : 8, got);
        repeat (8) @(posedge clk);
        chk(nm, exp_word(d, n9, x), got);
    endtask

    // hang guard
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        end_sim;
    end

    // main sequence
    initial begin
        {addr, wdata, wr, rd, sleep, bad_count, check_count} = '0;
        seed = 32'hBC8A;
        rst  = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(ustx_pkg::ADDR_CTRL, 8'hFF, ustx_pkg::CTRL_RST, "ctrl reset");
        rchk(ustx_pkg::ADDR_INTCTL, 8'h07, 8'h00, "intctl reset");
        rchk(ustx_pkg::ADDR_STAT, 8'h03, 8'h01, "stat reset");
        chk("pin idle", 9'h003, {7'h00, dt_out, ~dt_oe});
        wr_reg(3'h6, 8'hA5);
        rchk(3'h6, 8'hFF, 8'h00, "unmapped");
        $display("test reset done");
        // word waits while any setting is wrong, then goes out
        rnd;
        d1 = rv;
        wr_reg(ustx_pkg::ADDR_HOLD, d1);
        for (int k = 0; k < 6; k++) begin
            wr_reg(ustx_pkg::ADDR_CTRL, OFF_CFG[k]);
            repeat (4) @(posedge clk);
            rchk(ustx_pkg::ADDR_STAT, 8'h03, 8'h00, "held while off");
        end
        wr_reg(ustx_pkg::ADDR_CTRL, 8'h51);
        send(1'b0, d1, 1'b0, "first byte");
        chk("drive on", 9'h001, {8'h00, dt_oe});
        $display("test config done");
        // random lengths and data, first one a hand-picked corner
        for (int k = 0; k < 5; k++) begin
            rnd;
            nine = rv[0] | (k == 0);
            b9   = rv[1] | (k == 0);
            rnd;
            d1 = (k == 0) ? 8'h00 : rv;
            wr_reg(ustx_pkg::ADDR_CTRL, {b9, 1'b1, nine, 5'h11});
            wr_reg(ustx_pkg::ADDR_HOLD, d1);
            send(nine, d1, b9, "random char");
        end
        $display("test random done");
        // sticky done event, mask and clear
        wr_reg(ustx_pkg::ADDR_IMASK, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq set", 9'h001, {8'h00, irq});
        wr_reg(ustx_pkg::ADDR_IFLAG, 8'h03);
        repeat (2) @(posedge clk);
        chk("irq clear", 9'h000, {8'h00, irq});
        rchk(ustx_pkg::ADDR_IFLAG, 8'h02, 8'h00, "iflag cleared");
        $display("test interrupt done");
        // two words queued while asleep
        wr_reg(ustx_pkg::ADDR_CTRL, 8'h51);
        sleep <= 1'b1;
        rnd;
        d1 = rv;
        rnd;
        d2 = rv;
        wr_reg(ustx_pkg::ADDR_HOLD, d1);
        repeat (4) @(posedge clk);
        wr_reg(ustx_pkg::ADDR_HOLD, d2);
        rchk(ustx_pkg::ADDR_STAT, 8'h0F, {5'h01, d1[0], 2'h2}, "second held");
        wr_reg(ustx_pkg::ADDR_HOLD, ~d2);
        rchk(ustx_pkg::ADDR_HOLD, 8'hFF, d2, "full write refused");
        wr_reg(ustx_pkg::ADDR_INTCTL, 8'h03);
        repeat (2) @(posedge clk);
        chk("no wake yet", 9'h000, {8'h00, wake});
        send(1'b0, d1, 1'b0, "sleep first");
        rchk(ustx_pkg::ADDR_STAT, 8'h0B, 8'h0B, "second moved");
        chk("wake only", 9'h002, {7'h00, wake, vec});
        wr_reg(ustx_pkg::ADDR_INTCTL, 8'h07);
        repeat (2) @(posedge clk);
        chk("vector", 9'h003, {7'h00, wake, vec});
        send(1'b0, d2, 1'b0, "sleep second");
        rchk(ustx_pkg::ADDR_IFLAG, 8'h03, 8'h03, "events sticky");
        $display("test sleep done");
        end_sim;
    end
endmodule

// ==== dv/ustx_master.sv ====
// model of the outside synchronous master that clocks the slave
// assumes: the bench asks for one character at a time
`timescale 1ns/1ps
module ustx_master (
    // link pins
    input  wire logic i_dt,
    output logic      o_ck
);
    // clock stands low outside frames
    initial o_ck = 1'b0;

    // one frame of n link periods, 160 ns each, data sampled on each rise
    task automatic frame(input int n, output logic [8:0] w);
        w = 9'h000;
        for (int i = 0; i < n; i++) begin
            #80 o_ck <= 1'b1;
            w[i] = i_dt;
            #80 o_ck <= 1'b0;
        end
    endtask
endmodule

// ==== hdl/ustx_pkg.sv ====
// constants and carrier types for the synchronous slave transmitter
// assumes: one 100 MHz system clock, 8-bit plain register port
package ustx_pkg;

    // register port geometry
    localparam int          ADDR_W      = 3;
    localparam int          DATA_W      = 8;

    // register offsets
    localparam logic [2:0]  ADDR_CTRL   = 3'h0;
    localparam logic [2:0]  ADDR_HOLD   = 3'h1;
    localparam logic [2:0]  ADDR_STAT   = 3'h2;
    localparam logic [2:0]  ADDR_IFLAG  = 3'h3;
    localparam logic [2:0]  ADDR_IMASK  = 3'h4;
    localparam logic [2:0]  ADDR_INTCTL = 3'h5;

    // reset values
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [2:0]  INTCTL_RST  = 3'h0;
    localparam logic [1:0]  IREG_RST    = 2'h0;

    // interrupt control bit positions
    localparam int          INT_TXIE    = 0;
    localparam int          INT_PERIPHERAL_INTERRUPT_ENABLE    = 1;
    localparam int          INT_GIE     = 2;

    // sticky event bit positions
    localparam int          EV_EMPTY    = 0;
    localparam int          EV_DONE     = 1;

    // status bit positions
    localparam int          ST_FLAG     = 0;
    localparam int          ST_BUSY     = 1;
    localparam int          ST_PIN      = 2;

    // character lengths in link clock periods, and the count value of the last bit
    localparam logic [3:0]  NBITS_8     = 4'h8;
    localparam logic [3:0]  NBITS_9     = 4'h9;
    localparam logic [3:0]  CNT_LAST    = 4'h1;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic ninth_transmit_data_bit;
        logic transmit_enable_bit;
        logic nine_bit_transmit_select;
        logic serial_port_enable;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic clock_source_select;
        logic sync_select;
    } ustx_ctrl_s;

    // holding register with its occupancy
    typedef struct packed {
        logic       full;
        logic [8:0] data;
    } ustx_hold_s;

    // shifter states
    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } ustx_state_e;

endpackage

// ==== hdl/ustx_top.sv ====
// synchronous slave transmitter: holding register, shift register, flag and wake logic
// assumes: link clock and data pin come from outside and are synchronised here
//
// How it works
// - the shifter only runs while the synchronous select bit is one.
// - with clock source select at zero the block is a slave and uses the outside clock.
// - with both receive enables at zero the block transmits, otherwise it stays off the pin.
// - the port only operates while the serial port enable bit is one.
// - slave shifting loads and shifts data the same way as a master transmitter would.
// - with two words queued the first moves to the shift register at once and goes out.
// - the second word waits in the holding register and the flag stays clear meanwhile.
// - after the first word ends the second moves to the shifter and the flag sets on the same clock edge.
// - flag with peripheral and transmit interrupt enables set wakes the sleeping core.
// - with the global enable also set the wake becomes a vector request.
// - the nine-bit select makes each character nine bits long.
// - the transmit enable bit must be set before a held word is sent.
// - writing the low byte to the holding register starts that character.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ustx_top (
    // system
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST,
    // register port
    input  wire logic [ustx_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [ustx_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                       I_WR,
    input  wire logic                       I_RD,
    output logic      [ustx_pkg::DATA_W-1:0] O_RDATA,
    // core power state
    input  wire logic                       I_SLEEP,
    // link pins
    input  wire logic                       I_CK,
    input  wire logic                       I_DT,
    output logic                            O_DT,
    output logic                            O_DT_OE,
    // interrupts
    output logic                            O_IRQ,
    output logic                            O_WAKE,
    output logic                            O_VECTOR
);

    ustx_pkg::ustx_ctrl_s  ctrl;
    ustx_pkg::ustx_hold_s  hold;
    ustx_pkg::ustx_state_e state;
    logic [2:0]            intctl;
    logic [1:0]            iflag;
    logic [1:0]            imask;
    logic [8:0]            sh;
    logic [3:0]            cnt;
    logic                  ck_s1, ck_s2, ck_s3;
    logic                  dt_s1, dt_s2;
    logic                  flag_q;
    logic                  tx_active;
    logic                  ck_fall;
    logic                  last_bit;
    logic                  done;
    logic                  load;
    logic                  next_load;
    logic                  wr_hold;
    logic                  tx_flag;
    logic [1:0]            ev;
    logic [1:0]            next_iflag;

    // address match used by both write and read decode
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction

    // clock pin is only sampled, never driven
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            dt_s1 <= 1'b1;
            dt_s2 <= 1'b1;
        end else begin
            ck_s1 <= I_CK;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            dt_s1 <= I_DT;
            dt_s2 <= dt_s1;
        end
    end

    // transmit mode decode
    assign tx_active = ctrl.sync_select
                     & ~ctrl.clock_source_select
                     & ~ctrl.single_receive_enable
                     & ~ctrl.continuous_receive_enable
                     & ctrl.serial_port_enable
                     & ctrl.transmit_enable_bit;

    // one bit per outside clock period, advanced on its falling edge
    assign ck_fall   = ck_s3 & ~ck_s2;
    assign last_bit  = (cnt == ustx_pkg::CNT_LAST);
    assign done      = (state == ustx_pkg::ST_SHIFT) & ck_fall & last_bit & tx_active;
    assign load      = (state == ustx_pkg::ST_IDLE) & hold.full & tx_active;
    assign next_load = load | (done & hold.full);
    assign wr_hold   = I_WR & hit(I_ADDR, ustx_pkg::ADDR_HOLD) & ~hold.full;
    assign tx_flag   = ~hold.full;

    // control registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl   <= ustx_pkg::ustx_ctrl_s'(ustx_pkg::CTRL_RST);
            intctl <= ustx_pkg::INTCTL_RST;
            imask  <= ustx_pkg::IREG_RST;
        end else if (I_WR) begin
            if (hit(I_ADDR, ustx_pkg::ADDR_CTRL)) begin
                ctrl <= ustx_pkg::ustx_ctrl_s'(I_WDATA);
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_INTCTL)) begin
                intctl <= I_WDATA[2:0];
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_IMASK)) begin
                imask <= I_WDATA[1:0];
            end
        end
    end

    // holding register, ninth bit taken from control at the low-byte write
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            hold <= '0;
        end else if (wr_hold) begin
            hold.full <= 1'b1;
            hold.data <= {ctrl.ninth_transmit_data_bit, I_WDATA};
        end else if (next_load) begin
            hold.full <= 1'b0;
        end
    end

    // shifter state
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= ustx_pkg::ST_IDLE;
        end else begin
            unique case (state)
                ustx_pkg::ST_IDLE: begin
                    if (load) begin
                        state <= ustx_pkg::ST_SHIFT;
                    end
                end
                ustx_pkg::ST_SHIFT: begin
                    if (!tx_active) begin
                        state <= ustx_pkg::ST_IDLE;
                    end else if (done && !hold.full) begin
                        state <= ustx_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // shift register, bit counter and data pin, lsb first as in master mode
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sh   <= '0;
            cnt  <= '0;
            O_DT <= 1'b1;
        end else if (next_load) begin
            sh   <= hold.data;
            cnt  <= ctrl.nine_bit_transmit_select ? ustx_pkg::NBITS_9
                                                  : ustx_pkg::NBITS_8;
            O_DT <= hold.data[0];
        end else if (state == ustx_pkg::ST_SHIFT && (!tx_active || done)) begin
            cnt  <= '0;
            O_DT <= 1'b1;
        end else if (state == ustx_pkg::ST_SHIFT && ck_fall) begin
            sh   <= {1'b0, sh[8:1]};
            cnt  <= cnt - ustx_pkg::CNT_LAST;
            O_DT <= sh[1];
        end
    end

    // data pin is driven only in slave transmit
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_DT_OE <= 1'b0;
        end else begin
            O_DT_OE <= tx_active;
        end
    end

    // sticky events, a set wins over a write-one clear
    assign ev = {done, tx_flag & ~flag_q};
    always_comb begin
        next_iflag = iflag | ev;
        if (I_WR && hit(I_ADDR, ustx_pkg::ADDR_IFLAG)) begin
            next_iflag = (iflag & ~I_WDATA[1:0]) | ev;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            iflag  <= ustx_pkg::IREG_RST;
            flag_q <= 1'b1;
        end else begin
            iflag  <= next_iflag;
            flag_q <= tx_flag;
        end
    end

    // interrupt, wake and vector outputs
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_IRQ    <= 1'b0;
            O_WAKE   <= 1'b0;
            O_VECTOR <= 1'b0;
        end else begin
            O_IRQ    <= |(next_iflag & imask);
            O_WAKE   <= tx_flag & intctl[ustx_pkg::INT_TXIE]
                              & intctl[ustx_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE];
            O_VECTOR <= tx_flag & intctl[ustx_pkg::INT_TXIE]
                              & intctl[ustx_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE] & intctl[ustx_pkg::INT_GIE];
        end
    end

    // read data, one cycle after the strobe; sleep is visible for software
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            O_RDATA <= '0;
            if (hit(I_ADDR, ustx_pkg::ADDR_CTRL)) begin
                O_RDATA <= ctrl;
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_HOLD)) begin
                O_RDATA <= hold.data[7:0];
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_STAT)) begin
                O_RDATA[ustx_pkg::ST_FLAG] <= tx_flag;
                O_RDATA[ustx_pkg::ST_BUSY] <= (state == ustx_pkg::ST_SHIFT);
                O_RDATA[ustx_pkg::ST_PIN]  <= dt_s2;
                O_RDATA[3]                 <= I_SLEEP;
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_IFLAG)) begin
                O_RDATA[1:0] <= iflag;
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_IMASK)) begin
                O_RDATA[1:0] <= imask;
            end
            if (hit(I_ADDR, ustx_pkg::ADDR_INTCTL)) begin
                O_RDATA[2:0] <= intctl;
            end
        end
    end

    // checks on mode decode, shifter and flags
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    AST_NO_SYNC: assert property (!ctrl.sync_select |=> state == ustx_pkg::ST_IDLE)
        else $error("shifter ran outside synchronous mode");
    AST_MASTER_OFF: assert property (ctrl.clock_source_select |=> !O_DT_OE)
        else $error("pin driven with clock source select set");
    AST_RX_OFF: assert property ((ctrl.single_receive_enable
            || ctrl.continuous_receive_enable) |=> !O_DT_OE && O_DT)
        else $error("pin driven in receive configuration");
    AST_TRANSMIT_ENABLE_BIT: assert property (!ctrl.transmit_enable_bit && hold.full
            |=> hold.full && state == ustx_pkg::ST_IDLE)
        else $error("word left holding register without transmit enable");
    AST_LOAD_FIRST: assert property (load |=> state == ustx_pkg::ST_SHIFT
            && !hold.full && O_DT == $past(hold.data[0]))
        else $error("first word not moved to shifter at once");
    AST_HOLD_WAIT: assert property (wr_hold && state == ustx_pkg::ST_SHIFT
            && !ck_fall && tx_active |=> hold.full && !tx_flag)
        else $error("second word did not wait");
    AST_REFILL: assert property (done && hold.full |=>
            state == ustx_pkg::ST_SHIFT && tx_flag ##1 iflag[ustx_pkg::EV_EMPTY])
        else $error("second word not moved after first completed");
    AST_WAKE: assert property (tx_flag && intctl[ustx_pkg::INT_TXIE]
            && intctl[ustx_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE] |=> O_WAKE)
        else $error("flag did not wake the core");
    AST_VECTOR: assert property (O_VECTOR |-> O_WAKE && $past(intctl[ustx_pkg::INT_GIE]))
        else $error("vector without wake or global enable");
    AST_NINE: assert property (next_load && ctrl.nine_bit_transmit_select
            |=> cnt == ustx_pkg::NBITS_9)
        else $error("nine-bit character length wrong");
    AST_START: assert property (wr_hold && tx_active && state == ustx_pkg::ST_IDLE
            |=> hold.full ##1 state == ustx_pkg::ST_SHIFT)
        else $error("holding write did not start a character");
    AST_BIT_PERIOD: assert property (state == ustx_pkg::ST_SHIFT && !ck_fall
            && tx_active && !next_load |=> $stable(cnt) && $stable(O_DT))
        else $error("bit advanced without an outside clock edge");
    AST_PORT_OFF: assert property (!ctrl.serial_port_enable
            |=> !O_DT_OE && state == ustx_pkg::ST_IDLE)
        else $error("port operated while disabled");

    // event capture, abort and bit order
    AST_DONE_EVENT: assert property (done |=> iflag[ustx_pkg::EV_DONE])
        else $error("done event lost against a clear");
    AST_FLAG_RISE: assert property (tx_flag && !flag_q |=> iflag[ustx_pkg::EV_EMPTY])
        else $error("flag rise not captured");
    AST_ABORT: assert property (state == ustx_pkg::ST_SHIFT && !tx_active
            |=> state == ustx_pkg::ST_IDLE && O_DT)
        else $error("character not abandoned when the port went off");
    AST_LSB_NEXT: assert property (state == ustx_pkg::ST_SHIFT && ck_fall
            && tx_active && !last_bit |=> O_DT == $past(sh[1]))
        else $error("next bit not presented after a clock fall");
    AST_DRIVE: assert property (tx_active |=> O_DT_OE)
        else $error("pin not driven in slave transmit");

endmodule
